// ==== rtl/spi_port.v ====
// Master/slave serial peripheral port with control, status and data registers
//
// Contract
// RL1: Interrupt only when enabled, transfer done set and global enable on.
// RL2: Nothing happens on the serial side unless the port is enabled.
// RL3: Bit order control one sends LSB first, zero sends MSB first.
// RL4: Master select one makes the port master, zero makes it slave.
// RL5: SS low as input in master mode drops to slave, sets done.
// RL6: Clock polarity one idles SCK high, zero idles it low.
// RL7: Phase zero samples on leading edge, phase one on trailing edge.
// RL8: Master SCK divides system clock by 4/16/64/128 or 2/8/32/64.
// RL9: Slave ignores rate bits and uses only the external SCK.
// RL10: Transfer done flag set after every completed byte.
// RL11: Transfer done cleared when the interrupt vector is taken.
// RL12: Status read seeing done, then data access, clears done.
// RL13: Writing data during a transfer sets the collision flag.
// RL14: Status read seeing collision, then data access, clears both flags.
// RL15: Unused status bits read as zero.
// RL16: Doubler bit doubles master SCK, shortest period two clocks.
// RL17: External master keeps SCK at or below a quarter system clock.
// RL18: Data write loads shifter and starts; master also starts SCK.
// RL19: Data read returns the last byte shifted in.
// RL20: Four modes, polarity times two plus phase; opposite shift edges.
// RL21: Eight bits each way per transfer, then SCK back to idle.
`include "spi_port_consts.vh"
`default_nettype none

module spi_port #(
    parameter XFER_BITS = 8
) (
    input  wire       core_clk_i,
    input  wire       rstn_i,
    input  wire [1:0] addr_i,
    input  wire [7:0] wdata_i,
    input  wire       wr_i,
    input  wire       rd_i,
    output wire [7:0] rdata_o,
    input  wire       global_irq_en_i,
    input  wire       irq_ack_i,
    output wire       irq_o,
    input  wire       ss_is_input_i,
    input  wire       ss_i,
    input  wire       sck_i,
    output wire       sck_o,
    output wire       sck_oe_n_o,
    input  wire       mosi_i,
    output wire       mosi_o,
    output wire       mosi_oe_n_o,
    input  wire       miso_i,
    output wire       miso_o,
    output wire       miso_oe_n_o
);

    // Half SCK period in system clocks for a rate choice
    function [6:0] half_period;
        input [1:0] sel;
        input       dbl;
        reg   [7:0] div;
        begin
            div = `SPI_DIV_N0;
            case ({dbl, sel})
                3'h0: div = `SPI_DIV_N0;
                3'h1: div = `SPI_DIV_N1;
                3'h2: div = `SPI_DIV_N2;
                3'h3: div = `SPI_DIV_N3;
                3'h4: div = `SPI_DIV_D0;
                3'h5: div = `SPI_DIV_D1;
                3'h6: div = `SPI_DIV_D2;
                default: div = `SPI_DIV_D3;
            endcase
            half_period = div[7:1];
        end
    endfunction

    // Pick the outgoing bit of a byte by position and order
    function pick_bit;
        input [7:0] byte_v;
        input [2:0] idx;
        input       lsb;
        begin
            if (lsb)
                pick_bit = byte_v[idx];
            else
                pick_bit = byte_v[3'd7 - idx];
        end
    endfunction

    // Shift one received bit into the receive shifter
    function [7:0] shift_in;
        input [7:0] sh;
        input       b;
        input       lsb;
        begin
            if (lsb)
                shift_in = {b, sh[7:1]};
            else
                shift_in = {sh[6:0], b};
        end
    endfunction

    localparam [31:0] LAST_BIT_W  = XFER_BITS - 1;
    localparam [31:0] LAST_EDGE_W = 2 * XFER_BITS - 1;
    localparam [3:0]  LAST_BIT    = LAST_BIT_W[3:0];
    localparam [4:0]  LAST_EDGE   = LAST_EDGE_W[4:0];

    wire [3:0] pins_s;
    wire       ss_s;
    wire       sck_s;
    wire       mosi_s;
    wire       miso_s;

    reg  [7:0] ctrl_q;
    reg        dbl_q;
    reg        done_q;
    reg        coll_q;
    reg        arm_done_q;
    reg        arm_coll_q;
    reg  [7:0] tx_sh_q;
    reg  [7:0] rx_sh_q;
    reg  [7:0] rx_buf_q;
    reg        busy_q;
    reg  [6:0] hcnt_q;
    reg  [4:0] edge_cnt_q;
    reg  [3:0] bit_cnt_q;
    reg  [2:0] out_idx_q;
    reg  [2:0] out_idx_d;
    reg        sck_q;
    reg        sck_prev_q;
    reg        tx_bit_q;
    reg  [7:0] rdata_q;
    reg        irq_q;
    reg        sck_oe_n_q;
    reg        mosi_oe_n_q;
    reg        miso_oe_n_q;
    reg        done_d;
    reg        coll_d;

    // Pins pass two flip-flops before any logic reads them
    spi_sync2 #(
        .WIDTH    (4),
        .INIT_VAL (1'b1)
    ) u_sync (
        .core_clk_i (core_clk_i),
        .rstn_i     (rstn_i),
        .async_i    ({ss_i, sck_i, mosi_i, miso_i}),
        .sync_o     (pins_s)
    );

    assign ss_s   = pins_s[3];
    assign sck_s  = pins_s[2];
    assign mosi_s = pins_s[1];
    assign miso_s = pins_s[0];

    // Control fields
    wire       en     = ctrl_q[`SPI_CTRL_ENABLE];
    wire       master = ctrl_q[`SPI_CTRL_MASTER];            // RL4
    wire       idle_clock_level   = ctrl_q[`SPI_CTRL_IDLE_CLOCK_LEVEL];
    wire       sample_edge_select   = ctrl_q[`SPI_CTRL_SAMPLE_EDGE_SELECT];
    wire       lsb    = ctrl_q[`SPI_CTRL_LSB];
    wire [1:0] rate   = {ctrl_q[`SPI_CTRL_RATE_HI],
                         ctrl_q[`SPI_CTRL_RATE_LO]};
    wire [6:0] half   = half_period(rate, dbl_q);             // RL8 RL16

    // Register port decode
    wire wr_ctrl  = wr_i && (addr_i == `SPI_ADDR_CTRL);
    wire wr_stat  = wr_i && (addr_i == `SPI_ADDR_STATUS);
    wire rd_stat  = rd_i && (addr_i == `SPI_ADDR_STATUS);
    wire wr_data  = wr_i && (addr_i == `SPI_ADDR_DATA);
    wire acc_data = (wr_i || rd_i) && (addr_i == `SPI_ADDR_DATA);

    // Mode fault: another master pulls SS low while we are master
    wire fault = en && master && ss_is_input_i && !ss_s;      // RL5

    // A data write while idle starts a transfer
    wire start = en && wr_data && !busy_q;                    // RL18 RL2

    // Master edges come from the divider
    wire m_edge  = en && master && busy_q && (hcnt_q == 7'h00);
    wire m_lead  = m_edge && !edge_cnt_q[0];
    wire m_trail = m_edge && edge_cnt_q[0];
    wire m_done  = m_edge && (edge_cnt_q == LAST_EDGE);       // RL21

    // Slave edges come from the synchronised external SCK
    wire s_act   = en && !master && !ss_s;                    // RL9
    wire s_edge  = s_act && (sck_s != sck_prev_q);
    wire s_lead  = s_edge && (sck_s != idle_clock_level);                 // RL6
    wire s_trail = s_edge && (sck_s == idle_clock_level);

    // Phase picks sample and setup edges, always opposite
    wire lead    = master ? m_lead : s_lead;
    wire trail   = master ? m_trail : s_trail;
    wire sample  = sample_edge_select ? trail : lead;                       // RL7 RL20
    wire setup   = sample_edge_select ? lead : trail;                       // RL7 RL20
    wire in_bit  = master ? miso_s : mosi_s;
    wire last_s  = sample && (bit_cnt_q == LAST_BIT);
    wire xdone   = master ? m_done : (last_s && !fault);      // RL10
    wire abort   = !en || fault || (!master && ss_s);
    wire [7:0] rx_next = shift_in(rx_sh_q, in_bit, lsb);      // RL3
    wire [7:0] tx_src  = start ? wdata_i : tx_sh_q;

    // Control register; a mode fault drops master select
    always @(posedge core_clk_i)
    begin
        if (!rstn_i)
            ctrl_q <= `SPI_CTRL_RESET;
        else
        begin
            if (wr_ctrl)
                ctrl_q <= wdata_i;
            if (fault)
                ctrl_q[`SPI_CTRL_MASTER] <= 1'b0;              // RL5
        end
    end

    // Doubler bit in the status register
    always @(posedge core_clk_i)
    begin
        if (!rstn_i)
            dbl_q <= `SPI_STAT_RESET;
        else if (wr_stat)
            dbl_q <= wdata_i[`SPI_STAT_DOUBLER];               // RL16
    end

    // Flag next values; setting events win over clears
    always @*
    begin
        done_d = done_q;
        coll_d = coll_q;
        if (acc_data && arm_coll_q)
        begin
            coll_d = 1'b0;                                    // RL14
            done_d = 1'b0;                                    // RL14
        end
        if (acc_data && arm_done_q)
            done_d = 1'b0;                                    // RL12
        if (irq_ack_i)
            done_d = 1'b0;                                    // RL11
        if (en && wr_data && busy_q)
            coll_d = 1'b1;                                    // RL13
        if (xdone || fault)
            done_d = 1'b1;                                    // RL10 RL5
    end

    // Flags and the status-read arming for the clear sequence
    always @(posedge core_clk_i)
    begin
        if (!rstn_i)
        begin
            done_q     <= `SPI_STAT_RESET;
            coll_q     <= `SPI_STAT_RESET;
            arm_done_q <= 1'b0;
            arm_coll_q <= 1'b0;
        end
        else
        begin
            done_q <= done_d;
            coll_q <= coll_d;
            if (rd_stat)
            begin
                arm_done_q <= done_q;                         // RL12
                arm_coll_q <= coll_q;                         // RL14
            end
            else if (acc_data)
            begin
                arm_done_q <= 1'b0;
                arm_coll_q <= 1'b0;
            end
        end
    end

    // Next position of the outgoing bit; moves on setup edges, back to zero on start or abort
    always @*
    begin
        out_idx_d = out_idx_q;
        if (abort || start)
            out_idx_d = 3'h0;
        else if (setup)
            out_idx_d = bit_cnt_q[2:0];                       // RL20
    end

    // Shift engine for both master and slave
    always @(posedge core_clk_i)
    begin
        if (!rstn_i)
        begin
            tx_sh_q    <= `SPI_DATA_RESET;
            rx_sh_q    <= `SPI_DATA_RESET;
            rx_buf_q   <= `SPI_DATA_RESET;
            busy_q     <= 1'b0;
            hcnt_q     <= 7'h00;
            edge_cnt_q <= 5'h00;
            bit_cnt_q  <= 4'h0;
            out_idx_q  <= 3'h0;
            sck_q      <= 1'b0;
            tx_bit_q   <= 1'b0;
        end
        else
        begin
            out_idx_q <= out_idx_d;
            tx_bit_q  <= pick_bit(tx_src, out_idx_d, lsb);    // RL3
            if (start)
                tx_sh_q <= wdata_i;                           // RL18
            if (abort)
            begin
                busy_q     <= 1'b0;                           // RL2 RL5
                hcnt_q     <= 7'h00;
                edge_cnt_q <= 5'h00;
                bit_cnt_q  <= 4'h0;
                sck_q      <= idle_clock_level;                           // RL6
            end
            else
            begin
                if (start && master)
                begin
                    busy_q     <= 1'b1;                       // RL18
                    hcnt_q     <= half - 7'h01;
                    edge_cnt_q <= 5'h00;
                    bit_cnt_q  <= 4'h0;
                    sck_q      <= idle_clock_level;
                end
                else if (m_edge)
                begin
                    sck_q      <= ~sck_q;                     // RL8
                    hcnt_q     <= half - 7'h01;
                    edge_cnt_q <= edge_cnt_q + 5'h01;
                    if (m_done)
                    begin
                        busy_q     <= 1'b0;                   // RL21
                        edge_cnt_q <= 5'h00;
                    end
                end
                else if (busy_q && master)
                    hcnt_q <= hcnt_q - 7'h01;
                else if (!busy_q)
                    sck_q <= idle_clock_level;                            // RL6
                if (sample)
                begin
                    rx_sh_q <= rx_next;                       // RL7
                    if (last_s)
                    begin
                        rx_buf_q  <= rx_next;                 // RL19
                        bit_cnt_q <= 4'h0;
                    end
                    else
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                    if (!master)
                        busy_q <= !last_s;
                end
            end
        end
    end

    // Edge detector on the synchronised slave clock; reset level matches
    // the synchroniser's so no false edge follows reset
    always @(posedge core_clk_i)
    begin
        if (!rstn_i)
            sck_prev_q <= 1'b1;
        else
            sck_prev_q <= sck_s;
    end

    // Pin drive enables, active low while driving
    always @(posedge core_clk_i)
    begin
        if (!rstn_i)
        begin
            sck_oe_n_q  <= 1'b1;
            mosi_oe_n_q <= 1'b1;
            miso_oe_n_q <= 1'b1;
        end
        else
        begin
            sck_oe_n_q  <= !(en && master);                   // RL4 RL2
            mosi_oe_n_q <= !(en && master);
            miso_oe_n_q <= !s_act;
        end
    end

    // Read data stands in the cycle after the read strobe
    always @(posedge core_clk_i)
    begin
        if (!rstn_i)
            rdata_q <= 8'h00;
        else if (!rd_i)
            rdata_q <= 8'h00;
        else if (addr_i == `SPI_ADDR_CTRL)
            rdata_q <= ctrl_q;
        else if (addr_i == `SPI_ADDR_STATUS)
            rdata_q <= {done_q, coll_q, 5'h00, dbl_q};       // RL15
        else if (addr_i == `SPI_ADDR_DATA)
            rdata_q <= rx_buf_q;                              // RL19
        else
            rdata_q <= 8'h00;
    end

    // Interrupt request
    always @(posedge core_clk_i)
    begin
        if (!rstn_i)
            irq_q <= 1'b0;
        else
            irq_q <= ctrl_q[`SPI_CTRL_IRQ_EN] && done_q
                     && global_irq_en_i;                      // RL1
    end

    assign rdata_o     = rdata_q;
    assign irq_o       = irq_q;
    assign sck_o       = sck_q;
    assign sck_oe_n_o  = sck_oe_n_q;
    assign mosi_o      = tx_bit_q;
    assign mosi_oe_n_o = mosi_oe_n_q;
    assign miso_o      = tx_bit_q;
    assign miso_oe_n_o = miso_oe_n_q;

endmodule

`default_nettype wire

// ==== rtl/spi_port_consts.vh ====
// Register map, field positions, reset values and rate divisors of the port
`ifndef SPI_PORT_CONSTS_VH
`define SPI_PORT_CONSTS_VH

// Register word addresses on the plain register port
`define SPI_ADDR_CTRL     2'h0
`define SPI_ADDR_STATUS   2'h1
`define SPI_ADDR_DATA     2'h2

// Control register field positions
`define SPI_CTRL_IRQ_EN   7
`define SPI_CTRL_ENABLE   6
`define SPI_CTRL_LSB      5
`define SPI_CTRL_MASTER   4
`define SPI_CTRL_IDLE_CLOCK_LEVEL     3
`define SPI_CTRL_SAMPLE_EDGE_SELECT     2
`define SPI_CTRL_RATE_HI  1
`define SPI_CTRL_RATE_LO  0

// Status register field positions
`define SPI_STAT_DONE     7
`define SPI_STAT_COLL     6
`define SPI_STAT_DOUBLER  0

// Reset values
`define SPI_CTRL_RESET    8'h00
`define SPI_STAT_RESET    1'b0
`define SPI_DATA_RESET    8'h00

// SCK divisors of the system clock, normal and doubled rate
`define SPI_DIV_N0        8'd4
`define SPI_DIV_N1        8'd16
`define SPI_DIV_N2        8'd64
`define SPI_DIV_N3        8'd128
`define SPI_DIV_D0        8'd2
`define SPI_DIV_D1        8'd8
`define SPI_DIV_D2        8'd32
`define SPI_DIV_D3        8'd64

`endif

// ==== rtl/spi_sync2.v ====
// Two-stage synchroniser for pin inputs
`default_nettype none

module spi_sync2 #(
    parameter       WIDTH    = 1,
    parameter [0:0] INIT_VAL = 1'b0
) (
    input  wire             core_clk_i,
    input  wire             rstn_i,
    input  wire [WIDTH-1:0] async_i,
    output wire [WIDTH-1:0] sync_o
);

    reg [WIDTH-1:0] meta_q;
    reg [WIDTH-1:0] sync_q;

    // First stage feeds only the second stage
    always @(posedge core_clk_i)
    begin
        if (!rstn_i)
        begin
            meta_q <= {WIDTH{INIT_VAL}};
            sync_q <= {WIDTH{INIT_VAL}};
        end
        else
        begin
            meta_q <= async_i;
            sync_q <= meta_q;
        end
    end

    assign sync_o = sync_q;

endmodule

`default_nettype wire

// ==== testbench/spi_port_checker.sv ====
// Bound checker of the serial port pins and register port
`default_nettype none
module spi_port_checker #(
    parameter XFER_BITS = 8
) (
    input wire logic       core_clk_i,
    input wire logic       rstn_i,
    input wire logic [1:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic       wr_i,
    input wire logic       rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic       global_irq_en_i,
    input wire logic       irq_o,
    input wire logic       ss_is_input_i,
    input wire logic       ss_i,
    input wire logic       sck_o,
    input wire logic       sck_oe_n_o,
    input wire logic       mosi_oe_n_o,
    input wire logic       miso_oe_n_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge core_clk_i);
    endclocking
    default disable iff (!rstn_i);
    logic       en_q;
    logic       dw_q;
    logic       sck_q;
    logic [7:0] gap_q;
    // Enable shadow, recent set-up write, clocks since SCK moved
    always @(posedge core_clk_i)
    begin
        sck_q <= sck_o;
        if (!rstn_i)
        begin
            en_q  <= 1'b0;
            dw_q  <= 1'b0;
            gap_q <= 8'hff;
        end
        else
        begin
            if (wr_i && addr_i == 2'h0)
                en_q <= wdata_i[6];
            dw_q  <= (wr_i && !addr_i[0]) || (dw_q && sck_o == sck_q);
            gap_q <= (sck_o != sck_q) ? 8'h00 : gap_q + {7'h0, gap_q != 8'hff};
        end
    end
    a_irq_gated: assert property (irq_o |-> $past(global_irq_en_i))
        else $error("irq without global enable");
    a_off_quiet: assert property (
        !en_q && !$past(en_q) |-> sck_oe_n_o && mosi_oe_n_o && miso_oe_n_o)
        else $error("disabled port drives a pin");
    a_rdata_idle: assert property (!rd_i |=> rdata_o == 8'h00)
        else $error("read data outside the read slot");
    a_status_res: assert property (
        rd_i && addr_i == 2'h1 |=> rdata_o[5:1] == 5'h00)
        else $error("reserved status bits not zero");
    a_hole_zero: assert property (
        rd_i && addr_i == 2'h3 |=> rdata_o == 8'h00)
        else $error("unmapped read not zero");
    a_sck_rate: assert property (
        sck_o != sck_q && !dw_q && !sck_oe_n_o
        |-> gap_q inside {8'h00, 8'h01, 8'h03, 8'h07, 8'h0f, 8'h1f, 8'h3f})
        else $error("SCK half period off the divider table");
    a_oe_pair: assert property (
        !sck_oe_n_o |-> !mosi_oe_n_o && $past(en_q))
        else $error("master pins driven while disabled");
    a_one_driver: assert property (!miso_oe_n_o |-> sck_oe_n_o)
        else $error("slave output while master");
    a_fault_drop: assert property (
        (ss_is_input_i && !ss_i && !sck_oe_n_o) [*4] |-> ##[0:3] sck_oe_n_o)
        else $error("master kept after SS fault");
endmodule
bind spi_port spi_port_checker #(.XFER_BITS(XFER_BITS)) chk (.*);
`default_nettype wire

// ==== testbench/spi_peer.sv ====
// Behavioural external slave device on the serial pins
`default_nettype none
module spi_peer (
    input  wire logic       sck_i,
    input  wire logic       mosi_i,
    input  wire logic       sel_i,
    input  wire logic [7:0] ctl_i,
    input  wire logic [7:0] tx_i,
    output var  logic       miso_o,
    output var  logic [7:0] rx_o
);
    timeunit 1ns;
    timeprecision 1ns;
    int   n = 0;
    logic lead;
    initial miso_o = 1'b0;
    // Bit k of the outgoing byte in the selected order
    function automatic logic pick(int k);
        return ctl_i[5] ? tx_i[k] : tx_i[7-k];
    endfunction
    // Phase zero puts the first bit out before the leading edge
    always @(posedge sel_i)
    begin
        n = 0;
        if (!ctl_i[2])
            miso_o = pick(0);
    end
    // A released line shows the inverse of its last value
    always @(negedge sel_i)
        miso_o = ~miso_o;
    // Sample and set-up on opposite clock edges
    always @(sck_i)
        if (sel_i)
        begin
            lead = sck_i != ctl_i[3];
            if (lead ^ ctl_i[2])
            begin
                rx_o = ctl_i[5] ? {mosi_i, rx_o[7:1]}
                                : {rx_o[6:0], mosi_i};
                n++;
            end
            else
                miso_o = n < 8 ? pick(n) : ~miso_o;
        end
endmodule
`default_nettype wire

// ==== testbench/tb.sv ====
// Self-checking bench of the serial port with a peer slave
`default_nettype none
`include "spi_port_consts.vh"
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        core_clk_i = 1'b0;
    logic        rstn_i = 1'b0;
    logic        wr_i = 1'b0;
    logic        rd_i = 1'b0;
    logic        gie = 1'b0;
    logic        ack = 1'b0;
    logic        ss_in = 1'b0;
    logic        ss = 1'b1;
    logic        sck = 1'b0;
    logic        mosi = 1'b0;
    logic        psel = 1'b0;
    logic        sck_p = 1'b0;
    logic [1:0]  addr = 2'h0;
    logic [7:0]  wd = 8'h00;
    logic [7:0]  ctl = 8'h00;
    logic [7:0]  ptx = 8'h00;
    logic [7:0]  v = 8'h00;
    logic [7:0]  got = 8'h00;
    logic [15:0] seed = 16'h68c2;
    wire  [7:0]  rdata;
    wire  [7:0]  prx;
    wire         irq, sck_o, mosi_o, miso_o, pmiso;
    int          fails = 0;
    int          n_tests = 0;
    int          cyc = 0;
    int          t_edge = 0;
    int          gap = 0;
    spi_port #(.XFER_BITS(8)) dut (
        .core_clk_i(core_clk_i), .rstn_i(rstn_i), .addr_i(addr),
        .wdata_i(wd), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata),
        .global_irq_en_i(gie), .irq_ack_i(ack), .irq_o(irq),
        .ss_is_input_i(ss_in), .ss_i(ss), .sck_i(sck), .sck_o(sck_o),
        .sck_oe_n_o(), .mosi_i(mosi), .mosi_o(mosi_o), .mosi_oe_n_o(),
        .miso_i(pmiso), .miso_o(miso_o), .miso_oe_n_o());
    spi_peer peer (.sck_i(sck_o), .mosi_i(mosi_o), .sel_i(psel),
        .ctl_i(ctl), .tx_i(ptx), .miso_o(pmiso), .rx_o(prx));
    // 20 MHz system clock
    initial
        forever #25 core_clk_i = ~core_clk_i;
    // Clocks between the last two SCK changes
    always @(posedge core_clk_i)
    begin
        cyc++;
        if (sck_o !== sck_p)
        begin
            gap = cyc - t_edge;
            t_edge = cyc;
        end
        sck_p = sck_o;
    end
    function automatic logic [15:0] lfsr(logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // SCK half period in clocks for a rate code and doubler
    function automatic int half(logic [1:0] r, logic d);
        int n;
        n = (r == 2'h0) ? 4 : (r == 2'h1) ? 16 : (r == 2'h2) ? 64 : 128;
        return d ? ((r == 2'h3) ? 32 : n / 4) : n / 2;
    endfunction
    task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic wr(logic [1:0] a, logic [7:0] d);
        @(posedge core_clk_i);
        addr <= a;
        wd   <= d;
        wr_i <= 1'b1;
        @(posedge core_clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(logic [1:0] a);
        @(posedge core_clk_i);
        addr <= a;
        rd_i <= 1'b1;
        @(posedge core_clk_i);
        rd_i <= 1'b0;
        #1 v = rdata;
    endtask
    // Poll status until the transfer is done
    task automatic wait_done();
        for (int k = 0; k < 1200; k++)
        begin
            rd(`SPI_ADDR_STATUS);
            if (v[7] === 1'b1)
                break;
        end
    endtask
    // One master byte, a colliding write, then flag clearing
    task automatic xfer(logic [7:0] c, logic d, logic [7:0] tx, pt);
        int h;
        h = half(c[1:0], d);
        wr(`SPI_ADDR_CTRL, c);
        wr(`SPI_ADDR_STATUS, {7'h00, d});
        ctl = c;
        ptx = pt;
        psel = 1'b1;
        wr(`SPI_ADDR_DATA, tx);
        wr(`SPI_ADDR_DATA, ~tx);
        wait_done();
        chk("status", v, {2'b11, 5'h00, d});
        rd(`SPI_ADDR_DATA);
        if (h > 2)
            chk("rx byte", v, pt);
        chk("peer byte", prx, tx);
        chk("sck gap", 8'(gap), 8'(h));
        chk("sck idle", {7'h0, sck_o}, {7'h0, c[3]});
        rd(`SPI_ADDR_STATUS);
        chk("flags", v, {7'h00, d});
        psel = 1'b0;
    endtask
    initial
    begin
        repeat (4) @(posedge core_clk_i);
        rstn_i <= 1'b1;
        rd(`SPI_ADDR_CTRL);
        chk("ctrl reset", v, 8'h00);
        wr(`SPI_ADDR_STATUS, 8'h3f);
        rd(`SPI_ADDR_STATUS);
        chk("status bits", v, 8'h01);
        wr(2'h3, 8'hff);
        rd(2'h3);
        chk("unmapped", v, 8'h00);
        // A disabled port ignores a data write
        wr(`SPI_ADDR_DATA, 8'h81);
        repeat (40) @(posedge core_clk_i);
        rd(`SPI_ADDR_STATUS);
        chk("idle", v, 8'h01);
        // Every mode, rate and doubler, random order and data
        for (int i = 0; i < 32; i++)
        begin
            seed = lfsr(seed);
            xfer({2'b01, seed[4], 1'b1, i[1:0], i[3:2]}, i[4],
                seed[15:8], seed[7:0]);
        end
        // Mode fault with SS as input, then the interrupt path
        wr(`SPI_ADDR_CTRL, 8'hd0);
        ss_in <= 1'b1;
        ss    <= 1'b0;
        gie   <= 1'b1;
        repeat (8) @(posedge core_clk_i);
        chk("irq on", {7'h0, irq}, 8'h01);
        rd(`SPI_ADDR_CTRL);
        chk("fault ctrl", v, 8'hc0);
        gie <= 1'b0;
        repeat (3) @(posedge core_clk_i);
        chk("irq masked", {7'h0, irq}, 8'h00);
        ack <= 1'b1;
        @(posedge core_clk_i);
        ack <= 1'b0;
        rd(`SPI_ADDR_STATUS);
        chk("ack clears", v, 8'h01);
        // Slave with rate bits set, clocked at an eighth of the system
        ss    <= 1'b1;
        ss_in <= 1'b0;
        wr(`SPI_ADDR_CTRL, 8'h43);
        wr(`SPI_ADDR_DATA, 8'h6c);
        ss <= 1'b0;
        for (int b = 7; b >= 0; b--)
        begin
            mosi <= b[0] ^ b[1] ^ (b > 5) ^ (b < 2);
            repeat (4) @(posedge core_clk_i);
            got[b] = miso_o;
            sck <= 1'b1;
            repeat (4) @(posedge core_clk_i);
            sck <= 1'b0;
        end
        ss <= 1'b1;
        wait_done();
        rd(`SPI_ADDR_DATA);
        chk("slave rx", v, 8'ha5);
        chk("slave tx", got, 8'h6c);
        rd(`SPI_ADDR_STATUS);
        chk("done clear", v, 8'h01);
        complete_run();
    end
    // Cut a hang short
    initial
    begin
        repeat (60000) @(posedge core_clk_i);
        fails++;
        complete_run();
    end
endmodule
`default_nettype wire
